// [pkg/uhtfc_pkg.sv]
package uhtfc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_DEV_ADDR   = 8'h04;
  localparam logic [7:0] OFF_FRAME_LOW  = 8'h08;
  localparam logic [7:0] OFF_FRAME_HIGH = 8'h0c;
  localparam logic [7:0] OFF_TOKEN_CMD  = 8'h10;
  localparam logic [7:0] OFF_SOF_THRESH = 8'h14;
  localparam logic [7:0] OFF_TABLE_LOW  = 8'h18;
  localparam logic [7:0] OFF_TABLE_MID  = 8'h1c;
  localparam logic [7:0] OFF_TABLE_TOP  = 8'h20;
  localparam logic [7:0] OFF_TEST_CFG   = 8'h24;

  // Control register fields
  localparam int BIT_MODULE_ENABLE = 0;
  localparam int BIT_FRAME_MARKER  = 1;
  localparam int BIT_RESUME        = 2;
  localparam int BIT_HOST_ROLE     = 3;
  localparam int BIT_TOKEN_BUSY    = 5;

  // Address register fields
  localparam int BIT_SLOW_RATE     = 7;
  localparam int ADDR_WIDTH        = 7;

  // Token command fields
  localparam int TOK_PID_LSB       = 4;
  localparam int TOK_EP_LSB        = 0;
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;

  // Frame number split
  localparam int FRAME_WIDTH       = 11;
  localparam int FRAME_LOW_WIDTH   = 8;

  // Descriptor table base layout
  localparam int TABLE_ALIGN_BITS  = 9;
  localparam int TABLE_LOW_LSB     = 1;
  localparam int TABLE_MID_LSB     = 16;
  localparam int TABLE_TOP_LSB     = 24;

  // Test and power config field
  localparam int TEST_CFG_LSB      = 4;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Frame marker timing
  localparam int SOF_PERIOD_US     = 1000;
  localparam int CLK_MHZ           = 40;
  localparam int SOF_CYCLES        = SOF_PERIOD_US * CLK_MHZ;

  typedef struct packed {
    logic       slow_rate;
    logic [6:0] bus_address;
    logic [3:0] pid;
    logic [3:0] endpoint;
  } uhtfc_token_type;

endpackage

// [src/uhtfc_frame_timer.sv]
`timescale 1ns/1ps
module uhtfc_frame_timer #(
  parameter int PERIOD = uhtfc_pkg::SOF_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic clear,
  output logic      tick_q
);

  logic [31:0] count_q;
  logic [31:0] count_d;
  wire         wrap = (count_q == 32'(PERIOD - 1));

  // Restart from zero so the first marker lands one full period after enable
  assign count_d = (clear || !run || wrap) ? 32'h0000_0000 : count_q + 32'h0000_0001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 32'h0000_0000;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= run && !clear && wrap;
    end
  end

endmodule

// [src/uhtfc_token_seq.sv]
`timescale 1ns/1ps
module uhtfc_token_seq (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       clear,
  input  wire logic                       start,
  input  wire uhtfc_pkg::uhtfc_token_type req,
  input  wire logic                       done,
  output logic                            busy_q,
  output logic                            issue_q,
  output uhtfc_pkg::uhtfc_token_type      token_q
);

  wire take = start && !busy_q && !clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q  <= 1'b0;
      issue_q <= 1'b0;
      token_q <= '0;
    end else begin
      issue_q <= take;
      if (take) begin
        token_q <= req; // [R18]
      end
      // Host reset aborts whatever was in flight
      if (clear) begin
        busy_q <= 1'b0; // [R4]
      end else if (take) begin
        busy_q <= 1'b1; // [R18]
      end else if (done) begin
        busy_q <= 1'b0; // [R18]
      end
    end
  end

endmodule

// [src/uhtfc_top.sv]
// Overview of operation
// [R1] Module enable powers module and circuitry
// [R2] Host mode: frame marker every millisecond
// [R3] Software checks busy before new token
// [R4] Host enable toggle resets host logic
// [R5] Software holds resume 10 or 25 ms
// [R6] Host resume release appends slow EOP
// [R7] Address top bit selects slow rate
// [R8] Seven-bit bus address in address register
// [R9] Eleven-bit frame number over two registers
// [R10] Received frame marker loads frame number
// [R11] Token codes: OUT 0001, IN 1001
// [R12] Software writes valid endpoint number
// [R13] Software sets guard count per packet
// [R14] Table base 512-byte aligned, low zero
// [R15] Table low register gives bits 15:9
// [R16] Table mid register gives bits 23:16
// [R17] Table top register gives bits 31:24
// [R18] Token write starts transaction, busy till done
`timescale 1ns/1ps
module uhtfc_top #(
  parameter int SOF_CYCLES = uhtfc_pkg::SOF_CYCLES
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic                            module_power_q,
  output logic                            host_logic_reset_q,
  output logic                            frame_marker_tx_q,
  output logic                            resume_drive_q,
  output logic                            slow_eop_q,
  output logic                            token_issue_q,
  output uhtfc_pkg::uhtfc_token_type      token_q,
  input  wire logic                       token_done,
  input  wire logic                       frame_marker_rx,
  input  wire logic [10:0]                frame_marker_rx_index,
  output logic [31:0]                     table_base_q,
  output logic [7:0]                      frame_guard_count_q,
  output logic [3:0]                      test_cfg_q
);

  // Stored software state
  logic        module_enable_q;
  logic        frame_marker_enable_q;
  logic        resume_q;
  logic        host_role_enable_q;
  logic        slow_rate_select_q;
  logic [6:0]  bus_address_field_q;
  logic [7:0]  frame_index_low_q;
  logic [2:0]  frame_index_high_q;
  logic [7:0]  token_cmd_q;
  logic [6:0]  table_base_low_bits_q;
  logic [7:0]  table_base_mid_bits_q;
  logic [7:0]  table_base_top_bits_q;

  // Bus data phase tracking
  logic        wr_pending_q;
  logic [7:0]  wr_offset_q;
  logic [31:0] rdata_d;

  // Token engine handshake
  logic        token_start_q;
  logic        token_in_progress;
  logic        tick;

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction

  function automatic logic valid_pid(input logic [3:0] pid);
    valid_pid = (pid == uhtfc_pkg::PID_OUT) || (pid == uhtfc_pkg::PID_IN) ||
                (pid == uhtfc_pkg::PID_SETUP);
  endfunction

  // Address phase decode
  wire        addr_phase = hsel && hready && htrans[1];
  wire        rd_take    = addr_phase && !hwrite;
  wire        wr_take    = addr_phase && hwrite;
  wire [7:0]  ap_offset  = {haddr[7:2], 2'b00};
  wire        word_hit   = (haddr[31:8] == 24'h00_0000);

  // Data phase write strobes
  wire        wr_ctrl  = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_CONTROL);
  wire        wr_addr  = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_DEV_ADDR);
  wire        wr_tok   = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_TOKEN_CMD);
  wire        wr_sof   = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_SOF_THRESH);
  wire        wr_tlow  = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_TABLE_LOW);
  wire        wr_tmid  = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_TABLE_MID);
  wire        wr_ttop  = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_TABLE_TOP);
  wire        wr_cfg   = wr_pending_q && (wr_offset_q == uhtfc_pkg::OFF_TEST_CFG);
  wire [7:0]  wbyte    = hwdata[7:0];

  // Next control values as the write would leave them
  wire        host_role_next = wr_ctrl ? wbyte[uhtfc_pkg::BIT_HOST_ROLE]
                                       : host_role_enable_q;
  wire        resume_next    = wr_ctrl ? wbyte[uhtfc_pkg::BIT_RESUME] : resume_q;
  wire        host_toggle    = host_role_next != host_role_enable_q; // [R4]
  wire        host_active    = module_enable_q && host_role_enable_q;

  // Busy must read set from the write onward, not a cycle later
  wire        busy_window = token_start_q || token_in_progress; // [R3]

  // Non-listed codes are stored but start nothing
  wire        token_go = wr_tok && host_active && !busy_window &&
                         valid_pid(wbyte[7:4]); // [R11]

  wire [7:0]  ctrl_byte = {2'b00, busy_window, 1'b0, host_role_enable_q,
                           resume_q, frame_marker_enable_q, module_enable_q};

  uhtfc_pkg::uhtfc_token_type token_req;
  assign token_req.slow_rate   = slow_rate_select_q; // [R7]
  assign token_req.bus_address = bus_address_field_q; // [R8]
  assign token_req.pid         = token_cmd_q[7:4]; // [R11]
  assign token_req.endpoint    = token_cmd_q[3:0];

  // Read mux, sampled at the address phase so hrdata is a flop
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (word_hit) begin
      unique case (ap_offset)
        uhtfc_pkg::OFF_CONTROL:    rdata_d = byte_word(ctrl_byte);
        uhtfc_pkg::OFF_DEV_ADDR:   rdata_d = byte_word({slow_rate_select_q,
                                                        bus_address_field_q});
        uhtfc_pkg::OFF_FRAME_LOW:  rdata_d = byte_word(frame_index_low_q); // [R9]
        uhtfc_pkg::OFF_FRAME_HIGH: rdata_d = byte_word({5'h00, frame_index_high_q}); // [R9]
        uhtfc_pkg::OFF_TOKEN_CMD:  rdata_d = byte_word(token_cmd_q);
        uhtfc_pkg::OFF_SOF_THRESH: rdata_d = byte_word(frame_guard_count_q);
        uhtfc_pkg::OFF_TABLE_LOW:  rdata_d = byte_word({table_base_low_bits_q, 1'b0});
        uhtfc_pkg::OFF_TABLE_MID:  rdata_d = byte_word(table_base_mid_bits_q);
        uhtfc_pkg::OFF_TABLE_TOP:  rdata_d = byte_word(table_base_top_bits_q);
        uhtfc_pkg::OFF_TEST_CFG:   rdata_d = byte_word({test_cfg_q, 4'h0});
        default:                   rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata       <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      wr_pending_q <= 1'b0;
      wr_offset_q  <= uhtfc_pkg::RESET_BYTE;
    end else begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      wr_pending_q <= wr_take && word_hit;
      wr_offset_q  <= ap_offset;
      if (rd_take) begin
        hrdata <= rdata_d;
      end
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_enable_q       <= 1'b0;
      frame_marker_enable_q <= 1'b0;
      resume_q              <= 1'b0;
      host_role_enable_q    <= 1'b0;
    end else if (wr_ctrl) begin
      module_enable_q       <= wbyte[uhtfc_pkg::BIT_MODULE_ENABLE]; // [R1]
      frame_marker_enable_q <= wbyte[uhtfc_pkg::BIT_FRAME_MARKER]; // [R2]
      resume_q              <= wbyte[uhtfc_pkg::BIT_RESUME]; // [R5]
      host_role_enable_q    <= wbyte[uhtfc_pkg::BIT_HOST_ROLE];
    end
  end

  // Address, token, guard count, table base and config registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_rate_select_q    <= 1'b0;
      bus_address_field_q   <= 7'h00;
      token_cmd_q           <= uhtfc_pkg::RESET_BYTE;
      frame_guard_count_q   <= uhtfc_pkg::RESET_BYTE;
      table_base_low_bits_q <= 7'h00;
      table_base_mid_bits_q <= uhtfc_pkg::RESET_BYTE;
      table_base_top_bits_q <= uhtfc_pkg::RESET_BYTE;
      test_cfg_q            <= 4'h0;
    end else begin
      if (wr_addr) begin
        slow_rate_select_q  <= wbyte[uhtfc_pkg::BIT_SLOW_RATE]; // [R7]
        bus_address_field_q <= wbyte[6:0]; // [R8]
      end
      // Writes while busy are dropped so the running command stays visible
      if (wr_tok && !busy_window) begin
        token_cmd_q <= wbyte; // [R18]
      end
      if (wr_sof) begin
        frame_guard_count_q <= wbyte; // [R13]
      end
      if (wr_tlow) begin
        table_base_low_bits_q <= wbyte[7:1]; // [R15]
      end
      if (wr_tmid) begin
        table_base_mid_bits_q <= wbyte; // [R16]
      end
      if (wr_ttop) begin
        table_base_top_bits_q <= wbyte; // [R17]
      end
      if (wr_cfg) begin
        test_cfg_q <= wbyte[7:4];
      end
    end
  end

  // Token start is delayed one cycle so the stored command feeds the engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      token_start_q <= 1'b0;
    end else begin
      token_start_q <= token_go; // [R18]
    end
  end

  uhtfc_token_seq u_token_seq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (host_logic_reset_q),
    .start   (token_start_q),
    .req     (token_req),
    .done    (token_done),
    .busy_q  (token_in_progress),
    .issue_q (token_issue_q),
    .token_q (token_q)
  );

  uhtfc_frame_timer #(
    .PERIOD (SOF_CYCLES)
  ) u_frame_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (host_active && frame_marker_enable_q), // [R2]
    .clear   (host_logic_reset_q),
    .tick_q  (tick)
  );

  // Frame number capture from received markers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_index_low_q  <= uhtfc_pkg::RESET_BYTE;
      frame_index_high_q <= 3'h0;
    end else if (frame_marker_rx && module_enable_q) begin
      frame_index_low_q  <= frame_marker_rx_index[7:0]; // [R10]
      frame_index_high_q <= frame_marker_rx_index[10:8]; // [R10]
    end
  end

  // Outward controls, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_power_q     <= 1'b0;
      host_logic_reset_q <= 1'b0;
      frame_marker_tx_q  <= 1'b0;
      resume_drive_q     <= 1'b0;
      slow_eop_q         <= 1'b0;
      table_base_q       <= 32'h0000_0000;
    end else begin
      module_power_q     <= module_enable_q; // [R1]
      host_logic_reset_q <= wr_ctrl && host_toggle; // [R4]
      frame_marker_tx_q  <= tick; // [R2]
      resume_drive_q     <= module_enable_q && resume_next;
      slow_eop_q         <= wr_ctrl && resume_q && !resume_next &&
                            host_active; // [R6]
      table_base_q       <= {table_base_top_bits_q, table_base_mid_bits_q,
                             table_base_low_bits_q,
                             {uhtfc_pkg::TABLE_ALIGN_BITS{1'b0}}}; // [R14]
    end
  end

endmodule

// [tb/uhtfc_sva.sv]
`timescale 1ns/1ps
module uhtfc_sva #(
  parameter int SOF_CYCLES = uhtfc_pkg::SOF_CYCLES
) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic                       module_power_q,
  input wire logic                       host_logic_reset_q,
  input wire logic                       frame_marker_tx_q,
  input wire logic                       resume_drive_q,
  input wire logic                       slow_eop_q,
  input wire logic                       token_issue_q,
  input wire uhtfc_pkg::uhtfc_token_type token_q,
  input wire logic [31:0]                table_base_q
);
  logic        ctl_wr_q;
  logic        host_q;
  logic [15:0] gap_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_wr_q <= 1'b0;
      host_q <= 1'b0;
      gap_q <= 16'h0000;
    end else begin
      ctl_wr_q <= hsel & hready & htrans[1] & hwrite & (haddr == 32'h0000_0000);
      if (ctl_wr_q) host_q <= hwdata[3];
      gap_q <= frame_marker_tx_q ? 16'h0000 : gap_q + 16'h0001;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ctl_wr;
    ctl_wr_q;
  endsequence
  sequence s_host_flip;
    ctl_wr_q && (hwdata[3] != host_q);
  endsequence
  // Enable lands at the data phase edge, the power output one edge later
  chk_power_write: assert property (s_ctl_wr |-> ##2 module_power_q == $past(hwdata[0], 2))
    else $error("module power differs from written bit");
  chk_host_reset: assert property (s_host_flip |-> ##[1:2] host_logic_reset_q)
    else $error("host reset pulse missing");
  chk_reset_pulse: assert property (host_logic_reset_q |=> !host_logic_reset_q)
    else $error("host reset pulse too long");
  chk_sof_gap: assert property (frame_marker_tx_q |-> gap_q >= SOF_CYCLES - 1)
    else $error("frame marker too early");
  chk_sof_gate: assert property (frame_marker_tx_q |-> module_power_q)
    else $error("frame marker while disabled");
  chk_issue_pulse: assert property (token_issue_q |=> !token_issue_q)
    else $error("token issue pulse too long");
  chk_token_hold: assert property ($changed(token_q) && !host_logic_reset_q |-> token_issue_q)
    else $error("token changed without issue");
  chk_eop_pulse: assert property (slow_eop_q |-> !resume_drive_q ##1 !slow_eop_q)
    else $error("slow end of packet misplaced");
  chk_table_align: assert property (table_base_q[8:0] == 9'h000)
    else $error("table base not aligned");
endmodule
bind uhtfc_top uhtfc_sva #(.SOF_CYCLES(SOF_CYCLES)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .module_power_q(module_power_q),
  .host_logic_reset_q(host_logic_reset_q), .frame_marker_tx_q(frame_marker_tx_q),
  .resume_drive_q(resume_drive_q), .slow_eop_q(slow_eop_q),
  .token_issue_q(token_issue_q), .token_q(token_q), .table_base_q(table_base_q));

// [tb/uhtfc_engine_model.sv]
`timescale 1ns/1ps
module uhtfc_engine_model (
  input wire logic        hclk,
  input wire logic        token_issue_q,
  input wire logic [7:0]  lat,
  input wire logic        sof_req,
  input wire logic [10:0] sof_idx,
  output logic            token_done,
  output logic            frame_marker_rx,
  output logic [10:0]     frame_marker_rx_index
);
  logic [7:0] cnt_q = 8'h00;
  initial token_done = 1'b0;
  initial frame_marker_rx = 1'b0;
  initial frame_marker_rx_index = 11'h000;
  // Index only valid with the marker; otherwise it keeps flipping
  always @(posedge hclk) begin
    token_done <= 1'b0;
    frame_marker_rx <= sof_req;
    frame_marker_rx_index <= sof_req ? sof_idx : ~frame_marker_rx_index;
    if (token_issue_q) cnt_q <= lat;
    else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      token_done <= (cnt_q == 8'h01);
    end
  end
endmodule

// [tb/usb_host_token_frame_ctrl_tb.sv]
`timescale 1ns/1ps
module usb_host_token_frame_ctrl_tb;
  localparam int SOF = 20;
  logic hclk, hresetn, hwrite, hreadyout, hresp, rd_dp, sof_req, sof_on, done, frx;
  logic mp, hrst_q, ftx, res, eop, iss;
  logic [1:0]  htrans;
  logic [7:0]  lat, gc, v, l, m, t;
  logic [3:0]  tc, ep, pid;
  logic [10:0] sof_idx, fidx;
  logic [31:0] haddr, hwdata, hrdata, tb_q;
  uhtfc_pkg::uhtfc_token_type tok, tq[$];
  logic [31:0] rq[$];
  int fail_count, checked, seed, ticks, gap, eops, hrst, n;
  always #12.5 hclk = ~hclk;
  uhtfc_top #(.SOF_CYCLES(SOF)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .module_power_q(mp), .host_logic_reset_q(hrst_q), .frame_marker_tx_q(ftx),
    .resume_drive_q(res), .slow_eop_q(eop), .token_issue_q(iss), .token_q(tok),
    .token_done(done), .frame_marker_rx(frx), .frame_marker_rx_index(fidx),
    .table_base_q(tb_q), .frame_guard_count_q(gc), .test_cfg_q(tc));
  uhtfc_engine_model u_eng (.hclk(hclk), .token_issue_q(iss), .lat(lat), .sof_req(sof_req),
    .sof_idx(sof_idx), .token_done(done), .frame_marker_rx(frx), .frame_marker_rx_index(fidx));
  task automatic print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) rq.push_back(e);
    wait_rdy();
    rd_dp <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d, 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, $random(seed), e);
  endtask
  always @(posedge hclk) begin
    if (rd_dp) chk("hrdata", rq.pop_front(), hrdata);
    if (rd_dp) chk("hresp", 32'h0, {31'h0, hresp});
    if (iss === 1'b1) begin
      if (tq.size() == 0) chk("token issue", 32'h0, 32'h1);
      else chk("token", {16'h0, tq.pop_front()}, {16'h0, tok});
    end
    gap++;
    if (ftx === 1'b1) begin
      ticks++;
      if (ticks > 1 && sof_on) chk("sof gap", SOF, gap);
      gap = 0;
    end
    eops += (eop === 1'b1);
    hrst += (hrst_q === 1'b1);
  end
  initial begin
    {hclk, hresetn, hwrite, rd_dp, sof_req, sof_on} = '0;
    {htrans, haddr, hwdata, sof_idx} = '0;
    {fail_count, checked, ticks, gap, eops, hrst} = '0;
    lat = 8'h01;
    seed = 6;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 11; i++) rd(32'(i * 4), 32'h0);
    rd(32'h100, 32'h0);
    v = $random(seed);
    wr(uhtfc_pkg::OFF_DEV_ADDR, {24'hffffff, v});
    rd(uhtfc_pkg::OFF_DEV_ADDR, {24'h0, v});
    {l, m, t} = 24'($random(seed));
    wr(uhtfc_pkg::OFF_TABLE_LOW, l);
    wr(uhtfc_pkg::OFF_TABLE_MID, m);
    wr(uhtfc_pkg::OFF_TABLE_TOP, t);
    rd(uhtfc_pkg::OFF_TABLE_LOW, {24'h0, l[7:1], 1'b0});
    rd(uhtfc_pkg::OFF_TABLE_TOP, {24'h0, t});
    chk("table base", {t, m, l[7:1], 9'h000}, tb_q);
    for (int i = 0; i < 2; i++) begin
      v = (i != 0) ? 8'h12 : 8'h4a;
      wr(uhtfc_pkg::OFF_SOF_THRESH, v);
      rd(uhtfc_pkg::OFF_SOF_THRESH, v);
      chk("guard count", v, gc);
    end
    wr(uhtfc_pkg::OFF_TEST_CFG, 32'hff);
    rd(uhtfc_pkg::OFF_TEST_CFG, 32'hf0);
    chk("test cfg", 32'hf, tc);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h1);
    // Power output follows the stored enable one edge later
    repeat (2) @(posedge hclk);
    chk("power", 32'h1, mp);
    sof_idx <= 11'($random(seed));
    sof_req <= 1'b1;
    @(posedge hclk);
    sof_req <= 1'b0;
    repeat (2) @(posedge hclk);
    rd(uhtfc_pkg::OFF_FRAME_LOW, sof_idx[7:0]);
    rd(uhtfc_pkg::OFF_FRAME_HIGH, sof_idx[10:8]);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h5);
    @(posedge hclk);
    chk("resume", 32'h1, res);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h1);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h9);
    wr(uhtfc_pkg::OFF_CONTROL, 32'hd);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h9);
    repeat (3) @(posedge hclk);
    chk("slow eop count", 32'h1, eops);
    for (int k = 0; k < 3; k++) begin
      pid = k == 0 ? uhtfc_pkg::PID_OUT : k == 1 ? uhtfc_pkg::PID_IN : uhtfc_pkg::PID_SETUP;
      {v, ep} = $random(seed);
      lat <= k == 1 ? 8'h0c : 8'h01;
      wr(uhtfc_pkg::OFF_DEV_ADDR, v);
      tq.push_back({v, pid, ep});
      wr(uhtfc_pkg::OFF_TOKEN_CMD, {pid, ep});
      @(posedge hclk);
      rd(uhtfc_pkg::OFF_CONTROL, 32'h29);
      if (k == 1) wr(uhtfc_pkg::OFF_TOKEN_CMD, {uhtfc_pkg::PID_OUT, ep});
      if (k == 1) rd(uhtfc_pkg::OFF_TOKEN_CMD, {24'h0, uhtfc_pkg::PID_IN, ep});
      repeat (20) @(posedge hclk);
      rd(uhtfc_pkg::OFF_CONTROL, 32'h9);
    end
    wr(uhtfc_pkg::OFF_TOKEN_CMD, 32'h25);
    rd(uhtfc_pkg::OFF_TOKEN_CMD, 32'h25);
    lat <= 8'h28;
    tq.push_back({v, 4'h9, 4'h3});
    wr(uhtfc_pkg::OFF_TOKEN_CMD, 32'h93);
    repeat (3) @(posedge hclk);
    wr(uhtfc_pkg::OFF_CONTROL, 32'h1);
    // Host reset pulse clears busy one edge after the write lands
    @(posedge hclk);
    rd(uhtfc_pkg::OFF_CONTROL, 32'h1);
    repeat (50) @(posedge hclk);
    chk("host resets", 32'h2, hrst);
    wr(uhtfc_pkg::OFF_CONTROL, 32'hb);
    ticks = 0;
    sof_on = 1'b1;
    for (n = 0; n < 200 && ticks < 4; n++) @(posedge hclk);
    if (n >= 200) chk("sof ticks", 32'h4, ticks);
    sof_on = 1'b0;
    wr(uhtfc_pkg::OFF_CONTROL, 32'h9);
    repeat (3) @(posedge hclk);
    n = ticks;
    repeat (60) @(posedge hclk);
    chk("sof stop", n, ticks);
    print_verdict();
  end
endmodule
